// ---- rtl/nvca_regs.vh ----
// Behaviour
// R1 - Table stores fill holding register only
// R2 - Go bit programs block, stalls CPU
// R3 - Reset or watchdog abort sets store fault
// R4 - Go bit blocked unless store arm set
// R5 - Unlock sequence must immediately precede go
// R6 - Hardware never clears store arm bit
// R7 - Region 01 or 11 selects ID space
// R8 - User ID and config ranges read/write
// R9 - Device/revision ID range is read only
// R10 - Table fetch copies byte, CPU stalls
// R11 - Fetch outside defined ranges returns zero
// R12 - Software loads pointer and latch first
// R13 - Locked or invalid config write faults
// R14 - Config byte write starts immediately, stalls
// R15 - Completion clears go, sets done flag
// R16 - New config applies when CPU resumes
// R17 - Done flag stays until software clears
// R18 - Unlock key register reads zero
// R19 - Unlock is 55h then AAh consecutively
`ifndef NVCA_REGS_VH
`define NVCA_REGS_VH

// --------------------
// Register byte offsets.
// --------------------
`define NVCA_OFS_CTRL    12'h000
`define NVCA_OFS_UNLOCK  12'h004
`define NVCA_OFS_TPTR    12'h008
`define NVCA_OFS_TLAT    12'h00C
`define NVCA_OFS_CMD     12'h010
`define NVCA_OFS_IRQ_STS 12'h014
`define NVCA_OFS_IRQ_MSK 12'h018

// --------------------
// Control register fields.
// --------------------
`define NVCA_CTRL_GO     0
`define NVCA_CTRL_ARM    1
`define NVCA_CTRL_FAULT  2
`define NVCA_CTRL_REG_LO 3
`define NVCA_CTRL_REG_HI 4
`define NVCA_CTRL_BUSY   5

// --------------------
// Command register fields and interrupt status fields.
// --------------------
`define NVCA_CMD_FETCH   0
`define NVCA_CMD_STORE   1
`define NVCA_IRQ_DONE    0
`define NVCA_IRQ_FAULT   1

// --------------------
// Region codes, unlock keys and address ranges.
// --------------------
`define NVCA_REGION_PFM  2'h2
`define NVCA_KEY_FIRST   8'h55
`define NVCA_KEY_SECOND  8'hAA
`define NVCA_UID_BASE    22'h200000
`define NVCA_UID_LAST    22'h20000F
`define NVCA_CFG_BASE    22'h300000
`define NVCA_CFG_LAST    22'h30000B
`define NVCA_DID_BASE    22'h3FFFFC
`define NVCA_DID_LAST    22'h3FFFFF

// --------------------
// Timing: times in ns and clock rate in MHz.
// --------------------
`define NVCA_CLK_MHZ     250
`define NVCA_T_PROG_NS   2000
`define NVCA_T_CFG_NS    1000
`define NVCA_T_FETCH_NS  8

`endif

// ---- rtl/nvca_top.v ----
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "nvca_regs.vh"

module nvca_top #(
    parameter BLOCK_BYTES = 64,                                      // Holding register size.
    parameter PROG_CYC    = (`NVCA_T_PROG_NS * `NVCA_CLK_MHZ + 999) / 1000, // Block program time.
    parameter CFG_CYC     = (`NVCA_T_CFG_NS * `NVCA_CLK_MHZ + 999) / 1000,  // Config write time.
    parameter FETCH_CYC   = (`NVCA_T_FETCH_NS * `NVCA_CLK_MHZ + 999) / 1000, // Fetch stall time.
    parameter [31:0] DEV_ID_WORD = 32'h0000A5C3                      // Arbitrary identity value.
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        config_lock_bit,
    input  wire        external_reset_pin,
    input  wire        wdt_timeout,
    output wire        cpu_stall,
    output reg         pf_we,
    output reg  [21:0] pf_addr,
    output reg  [7:0]  pf_wdata,
    output wire [95:0] cfg_active,
    output wire        irq
);

    // --------------------
    // Local constants and state codes.
    // --------------------
    localparam AW = $clog2(BLOCK_BYTES);  // Holding register index width.
    localparam [2:0] ST_IDLE  = 3'h0;     // Nothing in progress.
    localparam [2:0] ST_SHIFT = 3'h1;     // Holding bytes pushed to the array.
    localparam [2:0] ST_PROG  = 3'h2;     // Block programming time.
    localparam [2:0] ST_CFG   = 3'h3;     // Config or user ID byte write.
    localparam [2:0] ST_FETCH = 3'h4;     // Table fetch in the ID space.
    localparam [1:0] UK_NONE  = 2'h0;     // No key seen.
    localparam [1:0] UK_HALF  = 2'h1;     // First key seen.
    localparam [1:0] UK_OPEN  = 2'h2;     // Both keys seen.

    // --------------------
    // Storage.
    // --------------------
    reg  [7:0]    hold_r [0:BLOCK_BYTES-1]; // Flash block holding register.
    reg  [7:0]    uid_r  [0:15];            // User ID bytes.
    reg  [7:0]    cfg_r  [0:11];            // Stored configuration bytes.
    reg  [95:0]   cfg_act_r;                // Configuration seen by the system.

    // --------------------
    // Control state.
    // --------------------
    reg           go_r;          // Write in progress bit.
    reg           arm_r;         // Store arm bit.
    reg           fault_r;       // Store fault flag.
    reg  [1:0]    region_r;      // Region select field.
    reg  [21:0]   tptr_r;        // Table pointer.
    reg  [7:0]    tlat_r;        // Table latch.
    reg  [1:0]    ukey_r;        // Unlock sequence progress.
    reg  [2:0]    st_r;          // Sequencer state.
    reg  [15:0]   cnt_r;         // Cycle counter.
    reg  [AW-1:0] idx_r;         // Holding register byte index.
    reg  [1:0]    sts_r;         // Interrupt status.
    reg  [1:0]    msk_r;         // Interrupt mask.

    // --------------------
    // APB decode.
    // --------------------
    wire        acc      = psel & penable;                  // Access phase.
    wire        wr       = acc & pwrite;                    // Write takes effect.
    wire        hit_ctrl = (paddr == `NVCA_OFS_CTRL);       // Control register.
    wire        hit_ukey = (paddr == `NVCA_OFS_UNLOCK);     // Unlock key register.
    wire        hit_tptr = (paddr == `NVCA_OFS_TPTR);       // Table pointer.
    wire        hit_tlat = (paddr == `NVCA_OFS_TLAT);       // Table latch.
    wire        hit_cmd  = (paddr == `NVCA_OFS_CMD);        // Command register.
    wire        hit_sts  = (paddr == `NVCA_OFS_IRQ_STS);    // Interrupt status.
    wire        hit_msk  = (paddr == `NVCA_OFS_IRQ_MSK);    // Interrupt mask.
    wire        mapped   = hit_ctrl | hit_ukey | hit_tptr | hit_tlat |
                           hit_cmd | hit_sts | hit_msk;     // Any known offset.
    wire        idle     = (st_r == ST_IDLE);               // Sequencer free.
    wire        id_space = region_r[0];                     // R7
    wire        in_uid   = (tptr_r >= `NVCA_UID_BASE) && (tptr_r <= `NVCA_UID_LAST);
    wire        in_cfg   = (tptr_r >= `NVCA_CFG_BASE) && (tptr_r <= `NVCA_CFG_LAST);
    wire        in_did   = (tptr_r >= `NVCA_DID_BASE) && (tptr_r <= `NVCA_DID_LAST);

    // The go bit may only be raised from an idle sequencer, with the arm bit
    // already set by an earlier write and the unlock keys written just before.
    wire        go_req   = wr & hit_ctrl & pwdata[`NVCA_CTRL_GO] & idle;
    wire        go_ok    = go_req & arm_r & (ukey_r == UK_OPEN);      // R4 R5
    wire        go_pfm   = go_ok & (region_r == `NVCA_REGION_PFM);
    wire        cfg_bad  = (in_cfg & ~config_lock_bit) | ~(in_cfg | in_uid); // R13
    wire        go_id    = go_ok & id_space;
    wire        abort    = (external_reset_pin | wdt_timeout) & go_r;  // R3

    // A command write while the sequencer is busy is ignored.
    wire        cmd_fetch = wr & hit_cmd & pwdata[`NVCA_CMD_FETCH] & idle;
    wire        cmd_store = wr & hit_cmd & pwdata[`NVCA_CMD_STORE] & idle;

    // Completion events from the sequencer.
    wire        prog_end = (st_r == ST_PROG) && (cnt_r == 16'h0000);
    wire        cfg_end  = (st_r == ST_CFG) && (cnt_r == 16'h0000);
    wire        wr_done  = (prog_end | cfg_end) & ~abort;
    wire        fault_ev = abort | (go_id & cfg_bad);

    // --------------------
    // ID space read value for the table fetch.
    // --------------------
    reg [7:0] id_rd; // Byte addressed by the table pointer.
    always @* begin
        id_rd = 8'h00; // R11
        if (in_uid) begin
            id_rd = uid_r[tptr_r[3:0]]; // R8
        end else if (in_cfg) begin
            id_rd = cfg_r[tptr_r[3:0]]; // R8
        end else if (in_did) begin
            id_rd = DEV_ID_WORD[8*tptr_r[1:0] +: 8]; // R9
        end
    end

    // --------------------
    // Unlock key tracker: any other write breaks the sequence.
    // --------------------
    reg [1:0] ukey_nxt; // Next unlock progress.
    always @* begin
        ukey_nxt = ukey_r;
        if (wr) begin
            if (hit_ukey && pwdata[7:0] == `NVCA_KEY_FIRST) begin
                ukey_nxt = UK_HALF; // R19
            end else if (hit_ukey && pwdata[7:0] == `NVCA_KEY_SECOND &&
                         ukey_r == UK_HALF) begin
                ukey_nxt = UK_OPEN; // R19
            end else begin
                ukey_nxt = UK_NONE; // R5
            end
        end
    end

    // --------------------
    // Control register, table registers and interrupt registers.
    // --------------------
    always @(posedge clk) begin
        if (rst) begin
            go_r     <= 1'b0;
            arm_r    <= 1'b0;
            fault_r  <= 1'b0;
            region_r <= 2'h0;
            tptr_r   <= 22'h000000;
            tlat_r   <= 8'h00;
            ukey_r   <= UK_NONE;
            sts_r    <= 2'h0;
            msk_r    <= 2'h0;
        end else begin
            ukey_r <= ukey_nxt;
            // Software writes the arm bit, region and fault flag; only
            // software changes the arm bit.
            if (wr && hit_ctrl && idle) begin
                arm_r    <= pwdata[`NVCA_CTRL_ARM]; // R6
                region_r <= pwdata[`NVCA_CTRL_REG_HI:`NVCA_CTRL_REG_LO];
            end
            // Fault flag: hardware set wins over a software clear.
            if (fault_ev) begin
                fault_r <= 1'b1; // R3 R13
            end else if (wr && hit_ctrl) begin
                fault_r <= pwdata[`NVCA_CTRL_FAULT];
            end
            // Go bit: set on a valid start, cleared at the end or on abort.
            if (go_pfm || (go_id && !cfg_bad)) begin
                go_r <= 1'b1; // R2 R14
            end else if (wr_done || abort) begin
                go_r <= 1'b0; // R15
            end
            // Table pointer and latch; fetch result lands in the latch.
            if (wr && hit_tptr && idle) begin
                tptr_r <= pwdata[21:0];
            end
            if ((st_r == ST_FETCH) && (cnt_r == 16'h0000)) begin
                tlat_r <= id_rd; // R10 R11
            end else if (wr && hit_tlat && idle) begin
                tlat_r <= pwdata[7:0];
            end
            // Sticky status bits, cleared by writing one; set wins.
            sts_r[`NVCA_IRQ_DONE]  <= wr_done |
                (sts_r[`NVCA_IRQ_DONE] & ~(wr & hit_sts & pwdata[`NVCA_IRQ_DONE])); // R15 R17
            sts_r[`NVCA_IRQ_FAULT] <= fault_ev |
                (sts_r[`NVCA_IRQ_FAULT] & ~(wr & hit_sts & pwdata[`NVCA_IRQ_FAULT]));
            if (wr && hit_msk) begin
                msk_r <= pwdata[1:0];
            end
        end
    end

    // --------------------
    // Holding register: table stores in flash region only buffer bytes.
    // --------------------
    genvar gi;
    generate
        for (gi = 0; gi < BLOCK_BYTES; gi = gi + 1) begin : g_hold
            always @(posedge clk) begin
                if (rst) begin
                    hold_r[gi] <= 8'hFF;
                end else if (cmd_store && (region_r == `NVCA_REGION_PFM) &&
                             (tptr_r[AW-1:0] == gi)) begin
                    hold_r[gi] <= tlat_r; // R1
                end
            end
        end
    endgenerate

    // --------------------
    // Sequencer: block program, ID byte write and table fetch.
    // --------------------
    always @(posedge clk) begin
        if (rst) begin
            st_r     <= ST_IDLE;
            cnt_r    <= 16'h0000;
            idx_r    <= {AW{1'b0}};
            pf_we    <= 1'b0;
            pf_addr  <= 22'h000000;
            pf_wdata <= 8'h00;
        end else begin
            pf_we <= 1'b0;
            if (abort) begin
                st_r <= ST_IDLE; // R3
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        idx_r <= {AW{1'b0}};
                        if (go_pfm) begin
                            st_r <= ST_SHIFT; // R2
                        end else if (go_id && !cfg_bad) begin
                            st_r  <= ST_CFG; // R14
                            cnt_r <= CFG_CYC[15:0] - 16'h0001;
                        end else if (cmd_fetch && id_space) begin
                            st_r  <= ST_FETCH; // R10
                            cnt_r <= FETCH_CYC[15:0] - 16'h0001;
                        end
                    end
                    ST_SHIFT: begin
                        // One holding byte goes to the array per cycle.
                        pf_we    <= 1'b1;
                        pf_addr  <= {tptr_r[21:AW], idx_r};
                        pf_wdata <= hold_r[idx_r];
                        idx_r    <= idx_r + {{(AW-1){1'b0}}, 1'b1};
                        if (idx_r == BLOCK_BYTES[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
                            st_r  <= ST_PROG;
                            cnt_r <= PROG_CYC[15:0] - 16'h0001;
                        end
                    end
                    ST_PROG, ST_CFG, ST_FETCH: begin
                        // Timed phase; the done events act on the last count.
                        if (cnt_r == 16'h0000) begin
                            st_r <= ST_IDLE;
                        end else begin
                            cnt_r <= cnt_r - 16'h0001;
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // --------------------
    // ID byte storage: written at the end of the timed write, with an
    // implicit erase, so the byte simply takes the latch value.
    // --------------------
    integer k;
    always @(posedge clk) begin
        if (rst) begin
            for (k = 0; k < 16; k = k + 1) begin
                uid_r[k] <= 8'hFF;
            end
            for (k = 0; k < 12; k = k + 1) begin
                cfg_r[k] <= 8'hFF;
            end
        end else if (cfg_end && !abort) begin
            if (in_uid) begin
                uid_r[tptr_r[3:0]] <= tlat_r; // R8 R14
            end else if (in_cfg) begin
                cfg_r[tptr_r[3:0]] <= tlat_r; // R8 R14
            end
        end
    end

    // --------------------
    // Active configuration: updated only once the stall is over.
    // --------------------
    always @(posedge clk) begin
        if (rst) begin
            cfg_act_r <= {96{1'b1}};
        end else if (idle) begin
            for (k = 0; k < 12; k = k + 1) begin
                cfg_act_r[8*k +: 8] <= cfg_r[k]; // R16
            end
        end
    end

    // --------------------
    // Read mux.
    // --------------------
    reg [31:0] rdata; // Selected read value.
    always @* begin
        rdata = 32'h00000000;
        if (hit_ctrl) begin
            rdata[`NVCA_CTRL_GO]    = go_r;
            rdata[`NVCA_CTRL_ARM]   = arm_r;
            rdata[`NVCA_CTRL_FAULT] = fault_r;
            rdata[`NVCA_CTRL_REG_HI:`NVCA_CTRL_REG_LO] = region_r;
            rdata[`NVCA_CTRL_BUSY]  = ~idle;
        end else if (hit_ukey) begin
            rdata = 32'h00000000; // R18
        end else if (hit_tptr) begin
            rdata[21:0] = tptr_r;
        end else if (hit_tlat) begin
            rdata[7:0] = tlat_r;
        end else if (hit_sts) begin
            rdata[1:0] = sts_r;
        end else if (hit_msk) begin
            rdata[1:0] = msk_r;
        end
    end

    // --------------------
    // Outputs.
    // --------------------
    assign prdata     = (acc && !pwrite) ? rdata : 32'h00000000;
    assign pready     = 1'b1;
    assign pslverr    = acc & ~mapped;
    assign cpu_stall  = ~idle; // R2 R10 R14
    assign cfg_active = cfg_act_r;
    assign irq        = |(sts_r & msk_r);

endmodule

// ---- test/nvca_top_chk.sv ----
`timescale 1ns/1ps
`include "nvca_regs.vh"

// --------------------
// Port-level checker for the config and ID access block.
// --------------------
module nvca_chk #(
    parameter BLOCK_BYTES = 64
) (
    input logic        clk,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        config_lock_bit,
    input logic        external_reset_pin,
    input logic        wdt_timeout,
    input logic        cpu_stall,
    input logic        pf_we,
    input logic [21:0] pf_addr,
    input logic [7:0]  pf_wdata,
    input logic [95:0] cfg_active,
    input logic        irq
);
    wire       wr_acc = psel && penable && pwrite && pready; // Completed write.
    wire       rd_acc = psel && penable && !pwrite;           // Read access phase.
    logic [1:0] key_r;                                        // Keys seen: 1 first, 2 both.
    logic       arm_r;                                        // Shadow of the arm bit.
    logic [7:0] burst_r;                                      // Length of current strobe run.
    wire        irq_wr = wr_acc && (paddr == `NVCA_OFS_IRQ_STS ||
                         paddr == `NVCA_OFS_IRQ_MSK);         // Status or mask write.

    // Shadows key progress, the arm bit and the flash strobe run length.
    always @(posedge clk) begin
        if (rst) begin
            key_r   <= 2'h0;
            arm_r   <= 1'b0;
            burst_r <= 8'h00;
        end else begin
            if (wr_acc) begin
                key_r <= (paddr == `NVCA_OFS_UNLOCK && pwdata == 32'h55) ? 2'h1 :
                         (paddr == `NVCA_OFS_UNLOCK && pwdata == 32'hAA && key_r == 2'h1)
                         ? 2'h2 : 2'h0;
            end
            if (wr_acc && paddr == `NVCA_OFS_CTRL && !cpu_stall) begin
                arm_r <= pwdata[1];
            end
            burst_r <= pf_we ? burst_r + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // A go request made while the sequencer is idle.
    sequence s_go;
        wr_acc && paddr == `NVCA_OFS_CTRL && pwdata[0] && !cpu_stall;
    endsequence
    a_unlock_reads_zero: assert property (rd_acc && paddr == `NVCA_OFS_UNLOCK |-> prdata == 32'h0)
        else $error("Unlock key register read nonzero.");
    a_stall_has_cause: assert property ($rose(cpu_stall) |->
        $past(wr_acc && (paddr == `NVCA_OFS_CTRL || paddr == `NVCA_OFS_CMD)))
        else $error("Stall began without a start request.");
    a_go_needs_keys: assert property (s_go ##0 key_r != 2'h2 |=> !cpu_stall)
        else $error("Write started without unlock keys.");
    a_go_needs_arm: assert property (s_go ##0 !arm_r |=> !cpu_stall)
        else $error("Write started without arm bit.");
    a_arm_kept: assert property (rd_acc && paddr == `NVCA_OFS_CTRL |-> prdata[1] == arm_r)
        else $error("Arm bit differs from last software value.");
    a_irq_sticky: assert property ($fell(irq) |-> $past(irq_wr))
        else $error("Interrupt dropped without software clear.");
    a_cfg_on_resume: assert property ($changed(cfg_active) |->
        $past(cpu_stall, 2) && !$past(cpu_stall))
        else $error("Config changed outside resume point.");
    a_flash_in_stall: assert property (pf_we |-> cpu_stall)
        else $error("Flash strobe outside a stalled write.");
    a_burst_whole: assert property ($fell(pf_we) |-> burst_r == BLOCK_BYTES)
        else $error("Block write strobe count wrong.");
endmodule

bind nvca_top nvca_chk #(.BLOCK_BYTES(BLOCK_BYTES)) u_chk (.*);

// ---- test/test_nvca_top.sv ----
`timescale 1ns/1ps
`include "nvca_regs.vh"

// --------------------
// Self-checking bench driving the block over APB.
// --------------------
module test_nvca_top;
    logic        clk, rst, psel, penable, pwrite, lock, ext_rst, wdt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, cpu_stall, pf_we, irq, err;
    logic [21:0] pf_addr;
    logic [7:0]  pf_wdata, byte_a, byte_b;
    logic [95:0] cfg_active;
    int          mismatches, checks, cyc, wr_cnt;
    localparam logic [31:0] DEV_ID = 32'h00001234; // Arbitrary identity value.

    nvca_top #(.PROG_CYC(4), .CFG_CYC(4), .FETCH_CYC(1), .DEV_ID_WORD(DEV_ID)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .config_lock_bit(lock), .external_reset_pin(ext_rst), .wdt_timeout(wdt),
        .cpu_stall(cpu_stall), .pf_we(pf_we), .pf_addr(pf_addr), .pf_wdata(pf_wdata),
        .cfg_active(cfg_active), .irq(irq));

    // Free-running clock of 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Counts flash strobes, keeps two bytes, and cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pf_we === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            if (pf_addr == 22'h000045) byte_a <= pf_wdata;
            if (pf_addr == 22'h000046) byte_b <= pf_wdata;
        end
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Counts: checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Compares a register or data value.
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares a single port level.
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // One APB transfer: setup, access until pready, then one idle cycle.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    // Reads a register and compares the masked value.
    task automatic chk_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk32(rdat & m, e);
    endtask

    // Waits, with a bound, until the sequencer releases the stall.
    task automatic wait_idle();
        int n;
        n = 0;
        while (cpu_stall !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) chk1(1'b1, 1'b0);
    endtask

    // Keys followed at once by a go write carrying the given control bits.
    task automatic unlock_go(input logic [31:0] ctrl);
        wr(`NVCA_OFS_UNLOCK, 32'h55);
        wr(`NVCA_OFS_UNLOCK, 32'hAA);
        wr(`NVCA_OFS_CTRL, ctrl | 32'h1);
    endtask

    // Arms, loads pointer and latch, then starts a byte write.
    task automatic cfg_write(input logic [21:0] a, input logic [7:0] d, input logic [31:0] c);
        wr(`NVCA_OFS_CTRL, c);
        wr(`NVCA_OFS_TPTR, {10'h0, a});
        wr(`NVCA_OFS_TLAT, {24'h0, d});
        unlock_go(c);
    endtask

    // Points at an address and fetches its byte into the latch.
    task automatic fetch(input logic [21:0] a);
        wr(`NVCA_OFS_TPTR, {10'h0, a});
        wr(`NVCA_OFS_CMD, 32'h1);
        wait_idle();
    endtask

    initial begin
        {psel, penable, pwrite, ext_rst, wdt} = 5'h0;
        {paddr, pwdata} = 44'h0;
        lock = 1'b1;
        rst  = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_reg(`NVCA_OFS_UNLOCK, 32'hFFFFFFFF, 32'h0);
        chk_reg(`NVCA_OFS_CTRL, 32'h2, 32'h0);
        xfer(1'b0, 12'hFFC, 32'h0);
        chk1(err, 1'b1);
        $display("Test reset done");
        cfg_write(22'h300002, 8'h5A, 32'hA);
        #1 chk1(cpu_stall, 1'b1);
        wait_idle();
        chk_reg(`NVCA_OFS_CTRL, 32'h3, 32'h2);
        chk32({24'h0, cfg_active[23:16]}, 32'h5A);
        chk_reg(`NVCA_OFS_IRQ_STS, 32'h1, 32'h1);
        fetch(22'h300002);
        chk_reg(`NVCA_OFS_TLAT, 32'hFF, 32'h5A);
        cfg_write(22'h20000F, 8'hC3, 32'h1A);
        wait_idle();
        fetch(22'h20000F);
        chk_reg(`NVCA_OFS_TLAT, 32'hFF, 32'hC3);
        wr(`NVCA_OFS_IRQ_MSK, 32'h1);
        chk1(irq, 1'b1);
        wr(`NVCA_OFS_IRQ_STS, 32'h3);
        chk1(irq, 1'b0);
        $display("Test config write done");
        wr(`NVCA_OFS_UNLOCK, 32'h55);
        wr(`NVCA_OFS_TPTR, 32'h300002);
        wr(`NVCA_OFS_UNLOCK, 32'hAA);
        wr(`NVCA_OFS_CTRL, 32'hB);
        #1 chk1(cpu_stall, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(`NVCA_OFS_UNLOCK, (i == 0) ? 32'hAA : 32'h55);
            wr(`NVCA_OFS_UNLOCK, (i == 0) ? 32'h55 : (i == 1) ? 32'h5A : 32'h55);
            wr(`NVCA_OFS_CTRL, 32'hB);
            #1 chk1(cpu_stall, 1'b0);
        end
        wr(`NVCA_OFS_CTRL, 32'h8);
        unlock_go(32'h8);
        #1 chk1(cpu_stall, 1'b0);
        unlock_go(32'hA);
        #1 chk1(cpu_stall, 1'b0);
        chk_reg(`NVCA_OFS_CTRL, 32'h7, 32'h2);
        $display("Test unlock guard done");
        for (int i = 0; i < 3; i++) begin
            lock <= (i != 0);
            cfg_write((i == 0) ? 22'h300000 : (i == 1) ? 22'h3FFFFC : 22'h30000C, 8'h11, 32'hA);
            #1 chk1(cpu_stall, 1'b0);
            chk_reg(`NVCA_OFS_CTRL, 32'h5, 32'h4);
            chk_reg(`NVCA_OFS_IRQ_STS, 32'h3, 32'h2);
            wr(`NVCA_OFS_CTRL, 32'hA);
            wr(`NVCA_OFS_IRQ_STS, 32'h3);
        end
        chk32({24'h0, cfg_active[7:0]}, 32'hFF);
        $display("Test write faults done");
        wr(`NVCA_OFS_CTRL, 32'h1A);
        for (int i = 0; i < 4; i++) begin
            fetch(22'h3FFFFC + i);
            chk_reg(`NVCA_OFS_TLAT, 32'hFF, (DEV_ID >> (8 * i)) & 32'hFF);
        end
        fetch(22'h100000);
        chk_reg(`NVCA_OFS_TLAT, 32'hFF, 32'h0);
        $display("Test fetch done");
        wr(`NVCA_OFS_CTRL, 32'h12);
        wr(`NVCA_OFS_TPTR, 32'h45);
        wr(`NVCA_OFS_TLAT, 32'h3C);
        wr(`NVCA_OFS_CMD, 32'h2);
        chk32(wr_cnt, 32'h0);
        unlock_go(32'h12);
        #1 chk1(cpu_stall, 1'b1);
        wait_idle();
        chk32(wr_cnt, 32'h40);
        chk32({24'h0, byte_a}, 32'h3C);
        chk32({24'h0, byte_b}, 32'hFF);
        chk_reg(`NVCA_OFS_IRQ_STS, 32'h1, 32'h1);
        wr(`NVCA_OFS_IRQ_STS, 32'h3);
        $display("Test block write done");
        for (int j = 0; j < 2; j++) begin
            cfg_write(22'h300004, 8'h77, 32'hA);
            ext_rst <= (j == 0);
            wdt     <= (j == 1);
            @(posedge clk);
            ext_rst <= 1'b0;
            wdt     <= 1'b0;
            wait_idle();
            chk_reg(`NVCA_OFS_CTRL, 32'h5, 32'h4);
            wr(`NVCA_OFS_CTRL, 32'hA);
        end
        chk32({24'h0, cfg_active[39:32]}, 32'hFF);
        $display("Test abort done");
        print_verdict();
    end
endmodule
